/* logic/serial_link_test_pattern_gen.sv */
// serial link test pattern generator with apb register access
//
// Function
// [R1] transport sample test enable passes raw converter samples to the sample output
// [R2] four-bit mode field selects the pattern; zero disables, zero is default
// [R3] injection field: 00 sample input, 01 ten-bit phy, 10 eight-bit scrambler
// [R4] code 1 alternates 5555/aaaa, code 2 alternates all zeros/all ones
// [R5] codes 3 to 7 give prbs 31, 23, 15, 9, 7 with listed seeds
// [R6] code 8 gives a ramp wrapping at the injection point word width
// [R7] code e repeats the four user words continuously
// [R8] code f sends the four user words once then zero words
// [R9] sample point: one word per frame, shared by every sample
// [R10] phy point: advance per symbol, user words use bits 15 to 6
// [R11] scrambler point: advance per octet, user words use upper bits
// [R12] user words come from the user pattern registers
// [R13] returning to normal mode needs a soft reset write of 81 to index zero
// [R14] any change of mode or injection point restarts the pattern
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pattern_gen_defs.svh"

module serial_link_test_pattern_gen
    import pattern_gen_pkg::*;
#(
    parameter int ADDR_WIDTH = 16
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [15:0]           sample_in,
    input  wire logic [9:0]            symbol_in,
    input  wire logic [7:0]            octet_in,
    input  wire logic                  unit_advance,
    output logic      [15:0]           sample_out,
    output logic      [9:0]            symbol_out,
    output logic      [7:0]            octet_out,
    output logic                       sample_test_active,
    output logic                       pattern_active
);

    // ***************************************************************
    // register file
    // ***************************************************************
    logic [7:0]  xport_q, xport_d;
    logic [7:0]  itm_q, itm_d;
    logic [7:0]  user_q [8];
    logic [7:0]  user_d [8];
    logic [31:0] rdata_q, rdata_d;
    logic        err_q, err_d;
    logic [13:0] idx;
    logic        hit;
    logic        wr_en;
    logic        restart;
    logic [15:0] pat_word;
    logic [3:0]  status_user;

    assign idx = paddr[15:2];
    assign hit = (paddr[1:0] == 2'b00) &&
                 (idx == `IDX_SOFT_RESET || idx == `IDX_XPORT_TEST ||
                  idx == `IDX_ITM_CTRL || idx == `IDX_STATUS ||
                  (idx >= `IDX_USER_FIRST && idx <= `IDX_USER_LAST));
    assign wr_en = psel && penable && pwrite && ce && hit && pstrb[0];
    assign pready  = ce;
    assign pslverr = psel && penable && err_q;
    assign prdata  = rdata_q;

    // register writes and soft reset in the access phase, read data captured in the setup phase
    always_comb begin
        xport_d = xport_q;
        itm_d   = itm_q;
        user_d  = user_q;
        rdata_d = rdata_q;
        err_d   = err_q;
        if (psel && !penable && ce) begin
            err_d   = !hit;
            rdata_d = 32'h0000_0000;
            if (idx == `IDX_XPORT_TEST) begin
                rdata_d = {24'h00_0000, xport_q};
            end else if (idx == `IDX_ITM_CTRL) begin
                rdata_d = {24'h00_0000, itm_q};
            end else if (idx == `IDX_STATUS) begin
                rdata_d = {12'h000, status_user, pat_word};
            end else if (idx >= `IDX_USER_FIRST && idx <= `IDX_USER_LAST) begin
                rdata_d = {24'h00_0000, user_q[3'(idx - `IDX_USER_FIRST)]}; // R12
            end
            if (!hit) begin
                rdata_d = 32'h0000_0000;
            end
        end
        if (wr_en) begin
            if (idx == `IDX_SOFT_RESET && pwdata[7:0] == `SOFT_RESET_CODE) begin
                xport_d = `XPORT_RESET; // R13
                itm_d   = `ITM_RESET;   // R13
            end else if (idx == `IDX_XPORT_TEST) begin
                xport_d = pwdata[7:0];
            end else if (idx == `IDX_ITM_CTRL) begin
                itm_d = {2'b00, pwdata[5:0]};
            end else if (idx >= `IDX_USER_FIRST && idx <= `IDX_USER_LAST) begin
                user_d[3'(idx - `IDX_USER_FIRST)] = pwdata[7:0]; // R12
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xport_q <= `XPORT_RESET;
            itm_q   <= `ITM_RESET; // R2
            for (int k = 0; k < 8; k++) begin
                user_q[k] <= `USER_RESET;
            end
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (ce) begin
            xport_q <= xport_d;
            itm_q   <= itm_d;
            user_q  <= user_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // ***************************************************************
    // pattern generator
    // ***************************************************************
    mode_type       mode;
    point_type      point;
    user_state_type ust_q, ust_d;
    logic           phase_q, phase_d;
    logic [15:0]    ramp_q, ramp_d;
    logic [30:0]    lfsr_q, lfsr_d;
    logic [30:0]    lfsr_next;
    logic [15:0]    prbs_bits;
    logic [4:0]     width;
    logic [4:0]     degree;
    logic [4:0]     tap;
    logic [30:0]    seed;
    logic [15:0]    mask;
    logic [15:0]    user_word;
    logic [15:0]    raw_word;
    logic           active;
    logic           step;

    assign restart = (itm_d[5:0] != itm_q[5:0]) && ce; // R14
    assign step    = unit_advance && ce && active;
    assign status_user = ust_q[3:0];

    // decode mode and injection point
    always_comb begin
        mode   = mode_type'(itm_q[`ITM_MODE_MSB:`ITM_MODE_LSB]); // R2
        point  = point_type'(itm_q[`ITM_POINT_MSB:`ITM_POINT_LSB]); // R3
        active = (point != point_none);
        unique case (mode)
            mode_checker, mode_toggle, mode_prbs31, mode_prbs23, mode_prbs15,
            mode_prbs9, mode_prbs7, mode_ramp, mode_user_repeat,
            mode_user_single: ;
            default: active = 1'b0; // off and unused codes
        endcase
        unique case (point)
            point_sample:    width = `WIDTH_SAMPLE;    // R9
            point_phy:       width = `WIDTH_PHY;       // R10
            point_scrambler: width = `WIDTH_SCRAMBLER; // R11
            default:         width = `WIDTH_SAMPLE;
        endcase
        mask = 16'(17'h1_0000 >> (5'h10 - width)) - 16'h0001;
    end

    // polynomial and seed per prbs length
    always_comb begin
        degree = `DEG_PRBS9;
        tap    = `TAP_PRBS9;
        seed   = `SEED_PRBS9;
        unique case (mode)
            mode_prbs31: begin
                degree = `DEG_PRBS31; // R5
                tap    = `TAP_PRBS31;
            end
            mode_prbs23: begin
                degree = `DEG_PRBS23; // R5
                tap    = `TAP_PRBS23;
            end
            mode_prbs15: begin
                degree = `DEG_PRBS15; // R5
                tap    = `TAP_PRBS15;
            end
            mode_prbs7: begin
                degree = `DEG_PRBS7; // R5
                tap    = `TAP_PRBS7;
            end
            default: ;
        endcase
        // seed follows the incoming mode, so a restart loads the new sequence
        unique case (mode_type'(itm_d[3:0]))
            mode_prbs31: seed = `SEED_PRBS31; // R5 R14
            mode_prbs23: seed = `SEED_PRBS23;
            mode_prbs15: seed = `SEED_PRBS15;
            mode_prbs7:  seed = `SEED_PRBS7;
            default:     ;
        endcase
    end

    // one word of prbs bits per unit, msb first
    prbs_stepper #(
        .STATE_WIDTH (31),
        .WORD_WIDTH  (16)
    ) u_prbs_stepper (
        .state_in  (lfsr_q),
        .degree    (degree),
        .tap       (tap),
        .steps     (width),
        .state_out (lfsr_next),
        .bits_out  (prbs_bits)
    );

    // current user word, upper bits right justified to the word width
    always_comb begin
        user_word = 16'h0000;
        unique case (ust_q)
            user_w1:   user_word = {user_q[1], user_q[0]}; // R12
            user_w2:   user_word = {user_q[3], user_q[2]};
            user_w3:   user_word = {user_q[5], user_q[4]};
            user_w4:   user_word = {user_q[7], user_q[6]};
            user_zero: user_word = 16'h0000; // R8
        endcase
        user_word = user_word >> (5'h10 - width); // R10 R11
    end

    // current pattern word
    always_comb begin
        raw_word = 16'h0000;
        unique case (mode)
            mode_checker: raw_word = phase_q ? ~`CHECKER_WORD : `CHECKER_WORD; // R4
            mode_toggle:  raw_word = phase_q ? 16'hffff : 16'h0000; // R4
            mode_prbs31, mode_prbs23, mode_prbs15, mode_prbs9,
            mode_prbs7:   raw_word = prbs_bits; // R5
            mode_ramp:    raw_word = ramp_q; // R6
            mode_user_repeat, mode_user_single: raw_word = user_word; // R7 R8
            default:      raw_word = 16'h0000;
        endcase
        pat_word = raw_word & mask;
    end

    // advance once per unit of the chosen point, restart on reprogramming
    always_comb begin
        phase_d = phase_q;
        ramp_d  = ramp_q;
        lfsr_d  = lfsr_q;
        ust_d   = ust_q;
        if (restart) begin
            phase_d = 1'b0; // R14
            ramp_d  = 16'h0000;
            lfsr_d  = seed;
            ust_d   = user_w1;
        end else if (step) begin
            phase_d = !phase_q; // R4
            ramp_d  = (ramp_q + 16'h0001) & mask; // R6
            lfsr_d  = lfsr_next; // R5
            unique case (ust_q)
                user_w1:   ust_d = user_w2;
                user_w2:   ust_d = user_w3;
                user_w3:   ust_d = user_w4;
                user_w4:   ust_d = (mode == mode_user_single) ? user_zero : user_w1; // R7 R8
                user_zero: ust_d = user_zero; // R8
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 1'b0;
            ramp_q  <= 16'h0000;
            lfsr_q  <= `SEED_PRBS9;
            ust_q   <= user_w1;
        end else if (ce) begin
            phase_q <= phase_d;
            ramp_q  <= ramp_d;
            lfsr_q  <= lfsr_d;
            ust_q   <= ust_d;
        end
    end

    // ***************************************************************
    // output substitution
    // ***************************************************************
    logic [15:0] sample_q, sample_d;
    logic [9:0]  symbol_q, symbol_d;
    logic [7:0]  octet_q, octet_d;
    logic        xport_act_q, xport_act_d;
    logic        pat_act_q, pat_act_d;

    // replace data at the selected point with the pattern word
    always_comb begin
        xport_act_d = xport_q[`XPORT_SAMPLE_EN_BIT];
        pat_act_d   = active;
        sample_d    = sample_in;
        symbol_d    = symbol_in;
        octet_d     = octet_in;
        if (xport_q[`XPORT_SAMPLE_EN_BIT]) begin
            sample_d = sample_in; // R1
        end else if (active && point == point_sample) begin
            sample_d = pat_word; // R9
        end
        if (active && point == point_phy) begin
            symbol_d = pat_word[9:0]; // R10
        end
        if (active && point == point_scrambler) begin
            octet_d = pat_word[7:0]; // R11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_q    <= 16'h0000;
            symbol_q    <= 10'h000;
            octet_q     <= 8'h00;
            xport_act_q <= 1'b0;
            pat_act_q   <= 1'b0;
        end else if (ce) begin
            sample_q    <= sample_d;
            symbol_q    <= symbol_d;
            octet_q     <= octet_d;
            xport_act_q <= xport_act_d;
            pat_act_q   <= pat_act_d;
        end
    end

    assign sample_out         = sample_q;
    assign symbol_out         = symbol_q;
    assign octet_out          = octet_q;
    assign sample_test_active = xport_act_q;
    assign pattern_active     = pat_act_q;

endmodule // serial_link_test_pattern_gen

`default_nettype wire

/* logic/pattern_gen_defs.svh */
// register indices, field positions, reset values and seeds of the test pattern generator
`ifndef PATTERN_GEN_DEFS_SVH
`define PATTERN_GEN_DEFS_SVH

// ***************************************************************
// register indices (byte address is four times the index)
// ***************************************************************
`define IDX_SOFT_RESET      14'h0000
`define IDX_USER_FIRST      14'h0551
`define IDX_USER_LAST       14'h0558
`define IDX_XPORT_TEST      14'h0571
`define IDX_ITM_CTRL        14'h0573
`define IDX_STATUS          14'h05f0

// ***************************************************************
// fields and reset values
// ***************************************************************
`define SOFT_RESET_CODE     8'h81
`define XPORT_SAMPLE_EN_BIT 5
`define ITM_MODE_LSB        0
`define ITM_MODE_MSB        3
`define ITM_POINT_LSB       4
`define ITM_POINT_MSB       5
`define ITM_RESET           8'h00
`define XPORT_RESET         8'h00
`define USER_RESET          8'h00

// ***************************************************************
// pattern constants
// ***************************************************************
`define CHECKER_WORD        16'h5555
`define SEED_PRBS31         31'h0003afff
`define SEED_PRBS23         31'h00003aff
`define SEED_PRBS15         31'h000003af
`define SEED_PRBS9          31'h00000092
`define SEED_PRBS7          31'h00000007
`define DEG_PRBS31          5'h1f
`define TAP_PRBS31          5'h1c
`define DEG_PRBS23          5'h17
`define TAP_PRBS23          5'h12
`define DEG_PRBS15          5'h0f
`define TAP_PRBS15          5'h0e
`define DEG_PRBS9           5'h09
`define TAP_PRBS9           5'h05
`define DEG_PRBS7           5'h07
`define TAP_PRBS7           5'h06
`define WIDTH_SAMPLE        5'h10
`define WIDTH_PHY           5'h0a
`define WIDTH_SCRAMBLER     5'h08

`endif

/* logic/pattern_gen_pkg.sv */
// types shared by the test pattern generator
package pattern_gen_pkg;

    // pattern selection codes
    typedef enum logic [3:0] {
        mode_off         = 4'h0,
        mode_checker     = 4'h1,
        mode_toggle      = 4'h2,
        mode_prbs31      = 4'h3,
        mode_prbs23      = 4'h4,
        mode_prbs15      = 4'h5,
        mode_prbs9       = 4'h6,
        mode_prbs7       = 4'h7,
        mode_ramp        = 4'h8,
        mode_user_repeat = 4'he,
        mode_user_single = 4'hf
    } mode_type;

    // where the pattern replaces the data
    typedef enum logic [1:0] {
        point_sample    = 2'b00,
        point_phy       = 2'b01,
        point_scrambler = 2'b10,
        point_none      = 2'b11
    } point_type;

    // user word sequencer, one-hot
    typedef enum logic [4:0] {
        user_w1   = 5'b00001,
        user_w2   = 5'b00010,
        user_w3   = 5'b00100,
        user_w4   = 5'b01000,
        user_zero = 5'b10000
    } user_state_type;

endpackage

/* logic/prbs_stepper.sv */
// combinational lfsr stepper: advances a fibonacci lfsr a chosen number of bits
`timescale 1ns/1ps
`default_nettype none

module prbs_stepper #(
    parameter int STATE_WIDTH = 31,
    parameter int WORD_WIDTH  = 16
) (
    input  wire logic [STATE_WIDTH-1:0] state_in,
    input  wire logic [4:0]             degree,
    input  wire logic [4:0]             tap,
    input  wire logic [4:0]             steps,
    output logic      [STATE_WIDTH-1:0] state_out,
    output logic      [WORD_WIDTH-1:0]  bits_out
);

    logic [STATE_WIDTH-1:0] s;
    logic [STATE_WIDTH-1:0] mask;
    logic [WORD_WIDTH-1:0]  b;
    logic                   fb;

    // shift out lsb first, feedback re-enters at bit degree-1
    always_comb begin
        s    = state_in;
        b    = '0;
        fb   = 1'b0;
        mask = '0;
        for (int j = 0; j < STATE_WIDTH; j++) begin
            mask[j] = (j < int'(degree));
        end
        for (int i = 0; i < WORD_WIDTH; i++) begin
            if (i < int'(steps)) begin
                fb = s[0] ^ s[degree - tap];
                b  = {b[WORD_WIDTH-2:0], s[0]};
                s  = ({1'b0, s[STATE_WIDTH-1:1]} | (STATE_WIDTH'(fb) << (degree - 5'd1))) & mask;
            end
        end
        state_out = s;
        bits_out  = b;
    end

endmodule // prbs_stepper

`default_nettype wire

/* test/pattern_gen_checker.sv */
// port assertions of the test pattern generator
`timescale 1ns/1ps
`default_nettype none

module pattern_gen_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] sample_in,
    input wire logic [9:0]  symbol_in,
    input wire logic [7:0]  octet_in,
    input wire logic        unit_advance,
    input wire logic [15:0] sample_out,
    input wire logic [9:0]  symbol_out,
    input wire logic [7:0]  octet_out,
    input wire logic        sample_test_active,
    input wire logic        pattern_active
);
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pready_follow_a: assert property (pready == ce)
        else $error("pready differs from ce");
    error_phase_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    refused_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read gave data");
    pass_through_a: assert property (!pattern_active && !$past(pattern_active)
        && !$past(pattern_active, 2) && $past(ce) && $past(presetn)
        |-> sample_out == $past(sample_in) && symbol_out == $past(symbol_in)
        && octet_out == $past(octet_in))
        else $error("idle path not passing data");
    raw_sample_a: assert property (sample_test_active && $past(sample_test_active)
        && $past(ce) |-> sample_out == $past(sample_in))
        else $error("raw samples not passed");
    word_hold_a: assert property (pattern_active && $past(pattern_active)
        && !sample_test_active && !$past(sample_test_active) && !$past(unit_advance)
        && !$past(unit_advance, 2) && !$past(psel) && !$past(psel, 2) && !$past(psel, 3)
        |-> $stable(sample_out) && $stable(symbol_out) && $stable(octet_out))
        else $error("word moved without advance");
    freeze_a: assert property (!ce |=> $stable(symbol_out) && $stable(pattern_active))
        else $error("state moved with ce low");
    start_cause_a: assert property ($rose(pattern_active)
        |-> $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
        else $error("pattern started without write");
endmodule // pattern_gen_checker
`default_nettype wire

/* test/link_receiver_model.sv */
// receiver model: reads the generated word and consumes one unit
`timescale 1ns/1ps
`default_nettype none

module link_receiver_model (
    input  wire logic        pclk,
    input  wire logic [15:0] sample_out,
    input  wire logic [9:0]  symbol_out,
    input  wire logic [7:0]  octet_out,
    output logic             unit_advance
);
    // ****************
    // consume a unit
    // ****************
    initial unit_advance = 1'b0;

    // read mid-cycle, pulse advance once, gap adds idle cycles
    task automatic take(input logic [1:0] pt, input int gap, output logic [15:0] word);
        @(negedge pclk);
        word = (pt == 2'b00) ? sample_out : (pt == 2'b01) ? {6'h0, symbol_out} : {8'h0, octet_out};
        @(posedge pclk);
        unit_advance <= 1'b1;
        @(posedge pclk);
        unit_advance <= 1'b0;
        repeat (gap + 1) @(posedge pclk);
    endtask
endmodule // link_receiver_model
`default_nettype wire

/* test/test_serial_link_test_pattern_gen.sv */
// self-checking bench of the test pattern generator
`timescale 1ns/1ps
`default_nettype none
`include "pattern_gen_defs.svh"

module test_serial_link_test_pattern_gen
    import pattern_gen_pkg::*;
();
    // ****************
    // signals
    // ****************
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic        unit_advance, sample_test_active, pattern_active;
    logic [15:0] paddr, sample_in, sample_out;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [9:0]  symbol_in, symbol_out;
    logic [7:0]  octet_in, octet_out;
    logic [15:0] user_w [4];
    logic [7:0]  codes [15] = '{8'h01, 8'h12, 8'h21, 8'h03, 8'h04, 8'h15, 8'h06, 8'h16,
                                8'h26, 8'h27, 8'h18, 8'h0e, 8'h1e, 8'h2f, 8'h0f};
    int          bad_count, tests_run, cycles;

    serial_link_test_pattern_gen #(.ADDR_WIDTH(16)) i_serial_link_test_pattern_gen (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_in(sample_in), .symbol_in(symbol_in),
        .octet_in(octet_in), .unit_advance(unit_advance), .sample_out(sample_out),
        .symbol_out(symbol_out), .octet_out(octet_out),
        .sample_test_active(sample_test_active), .pattern_active(pattern_active));

    link_receiver_model i_link_receiver_model (.pclk(pclk), .sample_out(sample_out),
        .symbol_out(symbol_out), .octet_out(octet_out), .unit_advance(unit_advance));

    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end

    // ****************
    // tasks
    // ****************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // one apb transfer, held until pready is seen high, then one idle edge
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // reference lfsr: oldest bit out of bit 0, feedback into bit deg-1
    function automatic logic [15:0] prbs(inout logic [30:0] s, input int deg, tap, w);
        logic [15:0] word;
        word = 16'h0;
        for (int i = 0; i < w; i++) begin
            word = {word[14:0], s[0]};
            s = {1'b0, s[30:1]} | (31'(s[0] ^ s[deg-tap]) << (deg - 1));
        end
        return word;
    endfunction

    // select a pattern and compare n consumed words
    task automatic run(input logic [7:0] code, input int n, input int gap);
        int          degs [5] = '{31, 23, 15, 9, 7};
        int          taps [5] = '{28, 18, 14, 5, 6};
        logic [30:0] seeds [5] = '{`SEED_PRBS31, `SEED_PRBS23, `SEED_PRBS15, `SEED_PRBS9,
                                   `SEED_PRBS7};
        logic [30:0] s;
        logic [15:0] exp, got;
        int          w, p;
        w = (code[5:4] == 2'b00) ? 16 : (code[5:4] == 2'b01) ? 10 : 8;
        p = (code[3:0] >= 4'h3 && code[3:0] <= 4'h7) ? int'(code[3:0]) - 3 : 0;
        s = seeds[p];
        apb(1'b1, `IDX_ITM_CTRL, code);
        repeat (3) @(posedge pclk);
        for (int k = 0; k < n; k++) begin
            case (code[3:0])
                4'h1: exp = k[0] ? 16'haaaa : 16'h5555;
                4'h2: exp = k[0] ? 16'hffff : 16'h0000;
                4'h8: exp = 16'(k);
                4'he: exp = user_w[k%4] >> (16 - w);
                4'hf: exp = (k < 4) ? user_w[k%4] >> (16 - w) : 16'h0;
                default: exp = prbs(s, degs[p], taps[p], w);
            endcase
            i_link_receiver_model.take(code[5:4], gap, got);
            check($sformatf("word %0d of %h", k, code), 32'(exp & 16'((1 << w) - 1)), 32'(got));
        end
        $display("test %h done", code);
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        {presetn, ce, psel, penable, pwrite} = 5'b01000;
        {paddr, pwdata, pstrb} = {16'h0, 32'h0, 4'hf};
        {sample_in, symbol_in, octet_in} = {16'h0, 10'h2c3, 8'h5a};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values, refused address, user words
        apb(1'b0, `IDX_ITM_CTRL, 8'h0);
        check("mode reset", 32'(`ITM_RESET), rd);
        apb(1'b0, `IDX_XPORT_TEST, 8'h0);
        check("transport reset", 32'(`XPORT_RESET), rd);
        apb(1'b0, 14'h0100, 8'h0);
        check("refused flag", 32'h1, 32'(err));
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `IDX_USER_FIRST + 14'(i), 8'(8'h11 * (i + 1)));
            user_w[i/2][8*(i%2) +: 8] = 8'(8'h11 * (i + 1));
        end
        apb(1'b0, `IDX_USER_LAST, 8'h0);
        check("user byte", 32'h88, rd);
        // every mode and point, slow receiver on odd runs
        foreach (codes[i]) run(codes[i], 6, i % 2);
        run(8'h28, 258, 0);
        apb(1'b1, `IDX_ITM_CTRL, 8'h39);
        repeat (4) @(posedge pclk);
        check("inactive", 32'h0, 32'(pattern_active));
        // clock enable low freezes a running pattern
        apb(1'b1, `IDX_ITM_CTRL, 8'h12);
        repeat (3) @(posedge pclk);
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
        // raw samples override the pattern at the sample point
        apb(1'b1, `IDX_ITM_CTRL, 8'h01);
        apb(1'b1, `IDX_XPORT_TEST, 8'h20);
        sample_in <= 16'h1234;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check("raw sample", 32'h1234, 32'(sample_out));
        check("sample test flag", 32'h1, 32'(sample_test_active));
        @(posedge pclk);
        // soft reset returns to normal operation
        apb(1'b1, `IDX_SOFT_RESET, `SOFT_RESET_CODE);
        apb(1'b0, `IDX_ITM_CTRL, 8'h0);
        check("mode cleared", 32'h0, rd);
        apb(1'b0, `IDX_USER_FIRST, 8'h0);
        check("user kept", 32'h11, rd);
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        check("normal path", 32'h2c3, 32'(symbol_out));
        $display("test registers done");
        close_out();
    end
endmodule // test_serial_link_test_pattern_gen

bind serial_link_test_pattern_gen pattern_gen_checker i_pattern_gen_checker (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_in(sample_in), .symbol_in(symbol_in), .octet_in(octet_in),
    .unit_advance(unit_advance), .sample_out(sample_out), .symbol_out(symbol_out),
    .octet_out(octet_out), .sample_test_active(sample_test_active),
    .pattern_active(pattern_active));
`default_nettype wire
